// *** tb/srsd_regfile_model.sv ***
// Register file model that takes write-backs from the datapath
`timescale 1ns/1ps
module srsd_regfile_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Write-back
    input wire logic wb_valid,
    input wire logic wb_we,
    input wire logic [4:0] wb_index,
    input wire logic [63:0] wb_data,
    // Read port
    input wire logic [4:0] rd_index,
    output logic [63:0] rd_data
);
    logic [63:0] regs_reg [32];
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < 32; i++) regs_reg[i] <= 64'h0;
        end else if (wb_valid && wb_we) begin
            regs_reg[wb_index] <= wb_data;
        end
    end
    assign rd_data = regs_reg[rd_index];
endmodule // srsd_regfile_model

// *** tb/testbench.sv ***
// Randomised self-checking bench of the shift-right and subtract datapath
`timescale 1ns/1ps
module testbench;
    import srsd_pkg::*;
    logic ref_clk = 0, rst = 1, issue_valid = 0, mode64 = 0, wb_valid, wb_we, overflow_exc, unsupported;
    logic [31:0] instr = 32'h0;
    logic [63:0] first_source_reg = 64'h0, second_source_reg = 64'h0, wb_data, rd_data;
    logic [4:0] dest_index = 5'h0, wb_index, rd_index = 5'h0;
    int fail_count = 0, samples_checked = 0, rnd;
    srsd_funct_e fns [6] = '{SRSD_FN_SRA, SRSD_FN_LSR_IMM, SRSD_FN_ASR_REG, SRSD_FN_LSR_REG,
        SRSD_FN_SUB_TRAP, SRSD_FN_SUB_NOTRAP};
    always #10 ref_clk = ~ref_clk;
    srsd_datapath dut_u (.ref_clk(ref_clk), .rst(rst), .issue_valid(issue_valid), .instr(instr), .mode64(mode64),
        .first_source_reg(first_source_reg), .second_source_reg(second_source_reg), .dest_index(dest_index),
        .wb_valid(wb_valid), .wb_we(wb_we), .wb_index(wb_index), .wb_data(wb_data),
        .overflow_exc(overflow_exc), .unsupported(unsupported));
    srsd_regfile_model rf_u (.ref_clk(ref_clk), .rst(rst), .wb_valid(wb_valid), .wb_we(wb_we),
        .wb_index(wb_index), .wb_data(wb_data), .rd_index(rd_index), .rd_data(rd_data));
    task automatic end_sim();
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(string n, logic [63:0] seen, logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    function automatic logic [31:0] calc(logic [5:0] fn, logic [4:0] sa, logic [63:0] a, logic [63:0] b);
        logic [4:0] s;
        s = fn[2] ? a[4:0] : sa;
        case (fn)
            6'h03, 6'h07: calc = $signed(b[31:0]) >>> s;
            6'h02, 6'h06: calc = b[31:0] >> s;
            default: calc = a[31:0] - b[31:0];
        endcase
    endfunction
    task automatic run(logic [5:0] opc, logic [5:0] fn, logic [4:0] sa, logic [63:0] a, logic [63:0] b, logic m);
        logic [31:0] r;
        logic ov, we;
        logic [63:0] old, e;
        r = calc(fn, sa, a, b);
        ov = opc == 6'h0 && fn == SRSD_FN_SUB_TRAP && a[31] != b[31] && r[31] != a[31];
        we = opc == 6'h0 && !ov;
        e = m ? {{32{r[31]}}, r} : {32'h0, r};
        instr = {opc, 15'h0, sa, fn};
        first_source_reg = a;
        second_source_reg = b;
        mode64 = m;
        dest_index = 5'($urandom);
        rd_index = dest_index;
        issue_valid = 1;
        #1 old = rd_data;
        @(negedge ref_clk);
        issue_valid = 0;
        chk("wb_valid", wb_valid, 1);
        chk("wb_index", wb_index, rd_index);
        chk("unsupported", unsupported, opc != 6'h0);
        chk("overflow_exc", overflow_exc, ov);
        chk("wb_we", wb_we, we);
        if (opc == 6'h0) chk("wb_data", wb_data, e);
        @(negedge ref_clk);
        chk("regfile", rd_data, we ? e : old);
    endtask
    initial begin
        repeat (100000) @(posedge ref_clk);
        fail_count++;
        end_sim();
    end
    initial begin
        rnd = $urandom(32'hcf69);
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk) rst = 0;
        chk("wb_valid", wb_valid, 0);
        run(0, SRSD_FN_SRA, 31, 0, 64'hffffffff80000000, 1);
        run(0, SRSD_FN_LSR_REG, 0, 64'hffffffffffffffe1, 64'hffffffff80000000, 1);
        run(0, SRSD_FN_SUB_TRAP, 0, 64'hffffffff80000000, 1, 1);
        run(0, SRSD_FN_SUB_NOTRAP, 0, 64'hffffffff80000000, 1, 1);
        run(0, SRSD_FN_SUB_TRAP, 0, 64'h7fffffff, 64'hffffffffffffffff, 0);
        run(6'h01, SRSD_FN_SUB_NOTRAP, 0, 0, 0, 1);
        for (int i = 0; i < 300; i++) begin
            logic [31:0] x, y;
            x = $urandom;
            y = $urandom;
            run(0, fns[$urandom % 6], 5'($urandom), {{32{x[31]}}, x}, {{32{y[31]}}, y}, 1'($urandom));
        end
        end_sim();
    end
endmodule // testbench

// *** verilog/srsd_datapath.sv ***
// Shift-right and 32-bit subtract execution slice with overflow trap
//
// Function
// - Arithmetic right shift fills vacated high bits with copies of source bit 31.
// - Logical right shifts, immediate or register amount, fill vacated high bits with zeros.
// - Variable shifts use only low five bits of the amount register.
// - In 64-bit mode results are 32-bit words sign-extended from bit 31.
// - Operands not properly sign-extended give undefined results.
// - Subtract gives first source minus second source, 32-bit two's complement.
// - Trapping subtract raises overflow when carries out of bits 30 and 31 differ.
// - On overflow the register write is suppressed.
// - Non-trapping subtract gives the same result and never raises overflow.
`timescale 1ns/1ps
module srsd_datapath
    import srsd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Issue
    input wire logic issue_valid,
    input wire logic [31:0] instr,
    input wire logic mode64,
    input wire logic [63:0] first_source_reg,
    input wire logic [63:0] second_source_reg,
    input wire logic [4:0] dest_index,
    // Write-back
    output logic wb_valid,
    output logic wb_we,
    output logic [4:0] wb_index,
    output logic [63:0] wb_data,
    output logic overflow_exc,
    output logic unsupported
);
    import srsd_pkg::*;

    // =========================================
    // Decode
    function automatic logic is_ours(input logic [31:0] i);
        logic [5:0] f;
        f = i[FUNCT_MSB:FUNCT_LSB];
        is_ours = (i[OPC_MSB:OPC_LSB] == REGISTER_FORMAT_OPCODE) &&
            (f == SRSD_FN_SRA || f == SRSD_FN_LSR_IMM || f == SRSD_FN_ASR_REG ||
             f == SRSD_FN_LSR_REG || f == SRSD_FN_SUB_TRAP || f == SRSD_FN_SUB_NOTRAP);
    endfunction

    logic [5:0] funct;
    logic hit;
    logic by_reg;
    logic arith;
    logic is_sub;
    logic [AMT_W-1:0] amount;
    logic [31:0] shifted;
    logic [32:0] diff;
    logic c30;
    logic c31;
    logic ovf;
    logic [31:0] word;
    logic [63:0] result_next;

    always_comb begin
        funct = instr[FUNCT_MSB:FUNCT_LSB];
        hit = is_ours(instr);
        by_reg = (funct == SRSD_FN_ASR_REG) || (funct == SRSD_FN_LSR_REG);
        arith = (funct == SRSD_FN_SRA) || (funct == SRSD_FN_ASR_REG);
        is_sub = (funct == SRSD_FN_SUB_TRAP) || (funct == SRSD_FN_SUB_NOTRAP);
        amount = by_reg ? first_source_reg[AMT_W-1:0] : instr[SA_MSB:SA_LSB];
    end

    srsd_shifter #(
        .WIDTH(32)
    ) u_shift (
        .src(second_source_reg[31:0]),
        .amount(amount),
        .arith(arith),
        .shifted(shifted)
    );

    // =========================================
    // Subtract and overflow
    always_comb begin
        diff = {1'b0, first_source_reg[31:0]} + {1'b0, ~second_source_reg[31:0]} + 33'h1;
        c30 = first_source_reg[31] ^ ~second_source_reg[31] ^ diff[31];
        c31 = diff[32];
        ovf = (funct == SRSD_FN_SUB_TRAP) && (c30 != c31);
        word = is_sub ? diff[31:0] : shifted;
        // Upper half follows bit 31 in 64-bit mode, else zero
        result_next = {(mode64 ? {32{word[31]}} : 32'h0), word};
    end

    // =========================================
    // Write-back stage
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_valid <= 1'b0;
            wb_we <= 1'b0;
            overflow_exc <= 1'b0;
            unsupported <= 1'b0;
        end else begin
            wb_valid <= issue_valid;
            wb_we <= issue_valid && hit && !ovf;
            overflow_exc <= issue_valid && hit && ovf;
            unsupported <= issue_valid && !hit;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_data <= RESULT_RST;
            wb_index <= INDEX_RST;
        end else if (issue_valid) begin
            wb_data <= result_next;
            wb_index <= dest_index;
        end
    end

    // =========================================
    // Checks
    property p_arith_fill;
        @(posedge ref_clk) disable iff (rst)
        (issue_valid && hit && arith && mode64 && second_source_reg[31] && amount != 5'h00)
            |=> wb_data[31];
    endproperty
    a_arith_fill: assert property (p_arith_fill) else $error("arith shift lost sign fill");

    property p_logic_fill;
        @(posedge ref_clk) disable iff (rst)
        (issue_valid && hit && !arith && !is_sub && amount != 5'h00) |=> !wb_data[31];
    endproperty
    a_logic_fill: assert property (p_logic_fill) else $error("logical shift fill not zero");

    property p_amount_low;
        @(posedge ref_clk) disable iff (rst)
        (issue_valid && hit && by_reg && first_source_reg[4:0] == 5'h00)
            |=> wb_data[31:0] == $past(second_source_reg[31:0]);
    endproperty
    a_amount_low: assert property (p_amount_low) else $error("upper amount bits used");

    property p_sext;
        @(posedge ref_clk) disable iff (rst)
        (issue_valid && mode64) |=> wb_data[63:32] == {32{wb_data[31]}};
    endproperty
    a_sext: assert property (p_sext) else $error("result not sign-extended");

    property p_sub_value;
        @(posedge ref_clk) disable iff (rst)
        (issue_valid && hit && is_sub)
            |=> wb_data[31:0] == $past(first_source_reg[31:0]) - $past(second_source_reg[31:0]);
    endproperty
    a_sub_value: assert property (p_sub_value) else $error("wrong difference");

    property p_ovf;
        @(posedge ref_clk) disable iff (rst)
        (issue_valid && hit && funct == SRSD_FN_SUB_TRAP &&
         first_source_reg[31] != second_source_reg[31] && diff[31] != first_source_reg[31])
            |=> overflow_exc;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not raised");

    property p_no_write;
        @(posedge ref_clk) disable iff (rst)
        overflow_exc |-> !wb_we;
    endproperty
    a_no_write: assert property (p_no_write) else $error("write on overflow");

    property p_notrap;
        @(posedge ref_clk) disable iff (rst)
        (issue_valid && hit && funct == SRSD_FN_SUB_NOTRAP) |=> !overflow_exc && wb_we;
    endproperty
    a_notrap: assert property (p_notrap) else $error("non-trapping subtract trapped");

    property p_decode;
        @(posedge ref_clk) disable iff (rst)
        (issue_valid && instr[OPC_MSB:OPC_LSB] != REGISTER_FORMAT_OPCODE) |=> unsupported && !wb_we;
    endproperty
    a_decode: assert property (p_decode) else $error("foreign opcode accepted");

    property p_lsr_imm_value;
        @(posedge ref_clk) disable iff (rst)
        (issue_valid && hit && funct == SRSD_FN_LSR_IMM)
            |=> wb_data[31:0] == ($past(second_source_reg[31:0]) >> $past(instr[SA_MSB:SA_LSB]));
    endproperty
    a_lsr_imm_value: assert property (p_lsr_imm_value) else $error("wrong logical shift by field");

    property p_lsr_reg_value;
        @(posedge ref_clk) disable iff (rst)
        (issue_valid && hit && funct == SRSD_FN_LSR_REG)
            |=> wb_data[31:0] == ($past(second_source_reg[31:0]) >> $past(first_source_reg[4:0]));
    endproperty
    a_lsr_reg_value: assert property (p_lsr_reg_value) else $error("wrong logical shift by register");

    property p_asr_reg_neg;
        @(posedge ref_clk) disable iff (rst)
        (issue_valid && hit && funct == SRSD_FN_ASR_REG && second_source_reg[31])
            |=> wb_data[31:0] == ~(~$past(second_source_reg[31:0]) >> $past(first_source_reg[4:0]));
    endproperty
    a_asr_reg_neg: assert property (p_asr_reg_neg) else $error("wrong arithmetic shift by register");

    property p_upper_zero;
        @(posedge ref_clk) disable iff (rst)
        (issue_valid && !mode64) |=> wb_data[63:32] == 32'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper half not cleared");

    property p_trap_only;
        @(posedge ref_clk) disable iff (rst)
        (issue_valid && funct != SRSD_FN_SUB_TRAP) |=> !overflow_exc;
    endproperty
    a_trap_only: assert property (p_trap_only) else $error("overflow from other operation");

    property p_no_ovf;
        @(posedge ref_clk) disable iff (rst)
        (issue_valid && hit && funct == SRSD_FN_SUB_TRAP && first_source_reg[31] == second_source_reg[31])
            |=> !overflow_exc && wb_we;
    endproperty
    a_no_ovf: assert property (p_no_ovf) else $error("overflow on like signs");

    property p_index;
        @(posedge ref_clk) disable iff (rst)
        issue_valid |=> wb_valid && wb_index == $past(dest_index);
    endproperty
    a_index: assert property (p_index) else $error("destination not passed on");

    property p_unsup;
        @(posedge ref_clk) disable iff (rst)
        (issue_valid && !hit) |=> unsupported && !wb_we && !overflow_exc;
    endproperty
    a_unsup: assert property (p_unsup) else $error("unknown function written");

    property p_quiet;
        @(posedge ref_clk) disable iff (rst)
        !issue_valid |=> !wb_valid && !wb_we && !overflow_exc && !unsupported;
    endproperty
    a_quiet: assert property (p_quiet) else $error("write-back without issue");
endmodule // srsd_datapath

// *** verilog/srsd_pkg.sv ***
// Package of encodings and field positions for the shift-right and subtract datapath
package srsd_pkg;
    // =========================================
    // Instruction fields
    localparam int unsigned OPC_MSB = 31;
    localparam int unsigned OPC_LSB = 26;
    localparam int unsigned FUNCT_MSB = 5;
    localparam int unsigned FUNCT_LSB = 0;
    localparam int unsigned SA_MSB = 10;
    localparam int unsigned SA_LSB = 6;
    localparam int unsigned AMT_W = 5;
    localparam logic [5:0] REGISTER_FORMAT_OPCODE = 6'h00;
    // =========================================
    // Function codes
    typedef enum logic [5:0] {
        SRSD_FN_SRA = 6'h03,
        SRSD_FN_LSR_IMM = 6'h02,
        SRSD_FN_ASR_REG = 6'h07,
        SRSD_FN_LSR_REG = 6'h06,
        SRSD_FN_SUB_TRAP = 6'h22,
        SRSD_FN_SUB_NOTRAP = 6'h23
    } srsd_funct_e;
    // =========================================
    // Reset values
    localparam logic [63:0] RESULT_RST = 64'h0;
    localparam logic [4:0] INDEX_RST = 5'h00;
endpackage

// *** verilog/srsd_shifter.sv ***
// Right shifter of a 32-bit word with selectable fill
`timescale 1ns/1ps
module srsd_shifter #(
    parameter int unsigned WIDTH = 32
) (
    // Operand
    input wire logic [WIDTH-1:0] src,
    input wire logic [$clog2(WIDTH)-1:0] amount,
    input wire logic arith,
    // Result
    output logic [WIDTH-1:0] shifted
);
    // Amount port codes map one-to-one onto shift distances 0 to WIDTH-1 only for power-of-two widths
    if (WIDTH < 2 || (WIDTH & (WIDTH - 1)) != 0) begin : g_bad_width
        $error("srsd_shifter: WIDTH must be a power of two");
    end
    logic fill;
    logic [2*WIDTH-1:0] ext;
    always_comb begin
        fill = arith & src[WIDTH-1];
        ext = {{WIDTH{fill}}, src} >> amount;
        shifted = ext[WIDTH-1:0];
    end
endmodule // srsd_shifter
